// file: hdl/line_cfg_pkg.sv
// Purpose: shared constants and types for the line configuration pin decoder
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses

package line_cfg_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_PORTS  = 4;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] TRISTATE_REG_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_REG_OFFSET   = 8'h04;
    localparam logic [NUM_PORTS-1:0] TRISTATE_RESET   = 4'h0;

    // status register field positions
    localparam int ST_ATTEN_POS_LSB = 0;  // 2 bits
    localparam int ST_BUS_STYLE    = 2;
    localparam int ST_CODEC_LSB    = 4;   // 4 bits
    localparam int ST_HW_MODE      = 8;
    localparam int ST_GLOBAL_OE    = 9;
    localparam int ST_ACCESS       = 10;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // decoded configuration
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ATTEN_OFF = 2'h0,
        ATTEN_TX  = 2'h1,
        ATTEN_RX  = 2'h2
    } atten_pos_t;

    typedef enum logic [0:0] {
        BUS_STYLE_STROBE = 1'h0,   // data strobe plus read/write line
        BUS_STYLE_RDWR   = 1'h1    // separate read and write enables
    } bus_style_t;

    typedef enum logic [3:0] {
        CODE_NONE = 4'h0,
        CODE_B8ZS = 4'h1,
        CODE_HDB3 = 4'h2,
        CODE_AMI  = 4'h4
    } codec_t;

    typedef struct packed {
        atten_pos_t atten_pos;
        bus_style_t bus_style;
        codec_t     codec;
    } line_cfg_t;

    localparam line_cfg_t CFG_RESET = '{ATTEN_OFF, BUS_STYLE_STROBE, CODE_NONE};

    typedef enum logic [1:0] {
        ACC_IDLE   = 2'h1,
        ACC_ACTIVE = 2'h2
    } acc_state_t;

endpackage

// file: hdl/strap_decode.sv
// Purpose: combinational decode of the shared mode pins
// Assumes: three-level input sensed as a driven flag plus a level
// Notes:   host-mode fields outside this decode read as neutral values

`timescale 1ns/1ns

module strap_decode (
    input  wire logic                    hw_mode_in,
    input  wire logic                    atten_sel_driven_in,
    input  wire logic                    atten_sel_level_in,
    input  wire logic                    style_code_sel_in,
    input  wire logic                    unipolar_in,
    input  wire logic                    e1_mode_in,
    output line_cfg_pkg::line_cfg_t      cfg_out
);
    import line_cfg_pkg::*;

    // zero-substituting code for the active line rate
    function automatic codec_t subst_code(input logic e1);
        return e1 ? CODE_HDB3 : CODE_B8ZS;
    endfunction

    // decode of the pins according to the operating mode
    always_comb begin
        cfg_out = CFG_RESET;
        if (hw_mode_in) begin
            if (!atten_sel_driven_in)
                cfg_out.atten_pos = ATTEN_OFF;
            else if (atten_sel_level_in)
                cfg_out.atten_pos = ATTEN_RX;
            else
                cfg_out.atten_pos = ATTEN_TX;
            if (unipolar_in)
                cfg_out.codec = style_code_sel_in ? CODE_AMI : subst_code(e1_mode_in);
        end else begin
            cfg_out.bus_style = style_code_sel_in ? BUS_STYLE_RDWR : BUS_STYLE_STROBE;
        end
    end

endmodule

// file: hdl/line_config_pin_decode.sv
// Purpose: mode pin decode, host access gating and transmit driver tristate control
// Assumes: pins already synchronous to REF_CLK_IN; AXI4-Lite register access
// Notes:   tristate output is combinational so a low global enable acts at once

`timescale 1ns/1ns

module line_config_pin_decode #(
    parameter int PORTS = line_cfg_pkg::NUM_PORTS
) (
    input  wire logic                           REF_CLK_IN,
    input  wire logic                           RST_IN,
    // mode and shared pins
    input  wire logic                           HW_MODE_IN,
    input  wire logic                           CS_N_ATTEN_LEVEL_IN,
    input  wire logic                           ATTEN_SEL_DRIVEN_IN,
    input  wire logic                           STYLE_CODE_SEL_IN,
    input  wire logic                           UNIPOLAR_IN,
    input  wire logic                           E1_MODE_IN,
    input  wire logic                           OUTPUT_ENABLE_IN,
    // decoded results
    output line_cfg_pkg::line_cfg_t             LINE_CFG_OUT,
    output logic                                HOST_ACCESS_OUT,
    output logic [PORTS-1:0]                    TX_TRISTATE_OUT,
    // AXI4-Lite slave
    input  wire logic [line_cfg_pkg::ADDR_W-1:0] S_AXI_AWADDR_IN,
    input  wire logic                           S_AXI_AWVALID_IN,
    output logic                                S_AXI_AWREADY_OUT,
    input  wire logic [line_cfg_pkg::DATA_W-1:0] S_AXI_WDATA_IN,
    input  wire logic [3:0]                     S_AXI_WSTRB_IN,
    input  wire logic                           S_AXI_WVALID_IN,
    output logic                                S_AXI_WREADY_OUT,
    output logic [1:0]                          S_AXI_BRESP_OUT,
    output logic                                S_AXI_BVALID_OUT,
    input  wire logic                           S_AXI_BREADY_IN,
    input  wire logic [line_cfg_pkg::ADDR_W-1:0] S_AXI_ARADDR_IN,
    input  wire logic                           S_AXI_ARVALID_IN,
    output logic                                S_AXI_ARREADY_OUT,
    output logic [line_cfg_pkg::DATA_W-1:0]     S_AXI_RDATA_OUT,
    output logic [1:0]                          S_AXI_RRESP_OUT,
    output logic                                S_AXI_RVALID_OUT,
    input  wire logic                           S_AXI_RREADY_IN
);
    import line_cfg_pkg::*;

    // ----------------------------------------------------------------
    // pin decode
    // ----------------------------------------------------------------
    line_cfg_t  cfg_next;
    line_cfg_t  cfg_reg;
    logic       cs_n_prev_reg;
    acc_state_t acc_reg;

    strap_decode u_decode (
        .hw_mode_in        (HW_MODE_IN),
        .atten_sel_driven_in (ATTEN_SEL_DRIVEN_IN),
        .atten_sel_level_in  (CS_N_ATTEN_LEVEL_IN),
        .style_code_sel_in (STYLE_CODE_SEL_IN),
        .unipolar_in       (UNIPOLAR_IN),
        .e1_mode_in        (E1_MODE_IN),
        .cfg_out           (cfg_next)
    );

    // registered configuration to the port datapaths
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN)
            cfg_reg <= CFG_RESET;
        else
            cfg_reg <= cfg_next;
    end

    assign LINE_CFG_OUT = cfg_reg;

    // ----------------------------------------------------------------
    // chip select access gating
    // ----------------------------------------------------------------
    // previous chip select level, reset to inactive
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN)
            cs_n_prev_reg <= 1'b1;
        else
            cs_n_prev_reg <= CS_N_ATTEN_LEVEL_IN;
    end

    // access opens only on a falling chip select
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            acc_reg <= ACC_IDLE;
        end else begin
            case (acc_reg)
                ACC_IDLE: begin
                    if (!HW_MODE_IN && cs_n_prev_reg && !CS_N_ATTEN_LEVEL_IN)
                        acc_reg <= ACC_ACTIVE;
                end
                ACC_ACTIVE: begin
                    if (HW_MODE_IN || CS_N_ATTEN_LEVEL_IN)
                        acc_reg <= ACC_IDLE;
                end
                default: acc_reg <= ACC_IDLE;
            endcase
        end
    end

    assign HOST_ACCESS_OUT = (acc_reg == ACC_ACTIVE);

    // ----------------------------------------------------------------
    // driver tristate control
    // ----------------------------------------------------------------
    logic [PORTS-1:0] tristate_reg;
    logic [PORTS-1:0] sw_tristate;

    // software bits count only outside hardware mode
    assign sw_tristate = HW_MODE_IN ? '0 : tristate_reg;

    // global pin overrides every port at once
    assign TX_TRISTATE_OUT = {PORTS{!OUTPUT_ENABLE_IN}} | sw_tristate;

    // apart from the tristate outputs and its status register bit, nothing else depends on the global enable pin

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    logic              aw_held_reg;
    logic              w_held_reg;
    logic [ADDR_W-1:0] waddr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic              wstrb0_reg;
    logic              do_write;

    assign S_AXI_AWREADY_OUT = !aw_held_reg && !S_AXI_BVALID_OUT;
    assign S_AXI_WREADY_OUT  = !w_held_reg && !S_AXI_BVALID_OUT;
    assign do_write          = aw_held_reg && w_held_reg && !S_AXI_BVALID_OUT;

    // address and data are captured independently
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            waddr_reg   <= '0;
            wdata_reg   <= '0;
            wstrb0_reg  <= 1'b0;
        end else begin
            if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
                aw_held_reg <= 1'b1;
                waddr_reg   <= S_AXI_AWADDR_IN;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= S_AXI_WDATA_IN;
                wstrb0_reg <= S_AXI_WSTRB_IN[0];
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // write response, error for unmapped addresses
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_BRESP_OUT  <= RESP_OKAY;
        end else if (do_write) begin
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT  <= (waddr_reg == TRISTATE_REG_OFFSET ||
                                 waddr_reg == STATUS_REG_OFFSET) ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN)
            tristate_reg <= TRISTATE_RESET[PORTS-1:0];
        else if (do_write && waddr_reg == TRISTATE_REG_OFFSET && wstrb0_reg)
            tristate_reg <= wdata_reg[PORTS-1:0];
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] status_word;

    always_comb begin
        status_word = '0;
        status_word[ST_ATTEN_POS_LSB +: 2] = cfg_reg.atten_pos;
        status_word[ST_BUS_STYLE]       = cfg_reg.bus_style;
        status_word[ST_CODEC_LSB +: 4]  = cfg_reg.codec;
        status_word[ST_HW_MODE]         = HW_MODE_IN;
        status_word[ST_GLOBAL_OE]       = OUTPUT_ENABLE_IN;
        status_word[ST_ACCESS]          = HOST_ACCESS_OUT;
    end

    assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;

    // read data one cycle after the address is taken
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT  <= '0;
            S_AXI_RRESP_OUT  <= RESP_OKAY;
        end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RRESP_OUT  <= RESP_OKAY;
            case (S_AXI_ARADDR_IN)
                TRISTATE_REG_OFFSET: S_AXI_RDATA_OUT <= DATA_W'(tristate_reg);
                STATUS_REG_OFFSET:   S_AXI_RDATA_OUT <= status_word;
                default: begin
                    S_AXI_RDATA_OUT <= '0;
                    S_AXI_RRESP_OUT <= RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RREADY_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);

    a_atten_floating_off: assert property (
        HW_MODE_IN && !ATTEN_SEL_DRIVEN_IN |=> LINE_CFG_OUT.atten_pos == ATTEN_OFF)
        else $error("floating select did not disable attenuator");
    a_atten_level_pos: assert property (
        HW_MODE_IN && ATTEN_SEL_DRIVEN_IN |=>
        LINE_CFG_OUT.atten_pos == ($past(CS_N_ATTEN_LEVEL_IN) ? ATTEN_RX : ATTEN_TX))
        else $error("attenuator position does not follow select level");
    a_bus_style_map: assert property (
        !HW_MODE_IN |=> LINE_CFG_OUT.bus_style == bus_style_t'($past(STYLE_CODE_SEL_IN)))
        else $error("host bus style mismatch");
    a_subst_code: assert property (
        HW_MODE_IN && UNIPOLAR_IN && !STYLE_CODE_SEL_IN |=>
        LINE_CFG_OUT.codec == ($past(E1_MODE_IN) ? CODE_HDB3 : CODE_B8ZS))
        else $error("zero substitution code not selected");
    a_ami_code: assert property (
        HW_MODE_IN && UNIPOLAR_IN && STYLE_CODE_SEL_IN |=> LINE_CFG_OUT.codec == CODE_AMI)
        else $error("transparent code not selected");
    a_global_oe_off: assert property (
        !OUTPUT_ENABLE_IN |-> TX_TRISTATE_OUT == {PORTS{1'b1}})
        else $error("driver active while global enable low");
    a_oe_other_live: assert property (
        !OUTPUT_ENABLE_IN && !HW_MODE_IN && $fell(CS_N_ATTEN_LEVEL_IN) |=> HOST_ACCESS_OUT)
        else $error("host access blocked by global enable");
    a_sw_tristate_wr: assert property (
        do_write && waddr_reg == TRISTATE_REG_OFFSET && wstrb0_reg ##1
        OUTPUT_ENABLE_IN && !HW_MODE_IN |-> TX_TRISTATE_OUT == $past(wdata_reg[PORTS-1:0]))
        else $error("software tristate bits not applied per port");
    a_port_enable_or: assert property (
        OUTPUT_ENABLE_IN && HW_MODE_IN |-> TX_TRISTATE_OUT == '0)
        else $error("port tristated without cause");
    a_access_needs_fall: assert property (
        $rose(HOST_ACCESS_OUT) |-> $past(cs_n_prev_reg, 1) && !$past(CS_N_ATTEN_LEVEL_IN))
        else $error("access opened without falling chip select");

    c_host_access: cover property ($rose(HOST_ACCESS_OUT) ##[1:8] !HOST_ACCESS_OUT);
    c_sw_tristate: cover property (do_write ##1 |TX_TRISTATE_OUT && OUTPUT_ENABLE_IN);
    c_atten_rx:    cover property (LINE_CFG_OUT.atten_pos == ATTEN_RX);
    c_read_status: cover property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN);

endmodule

// file: verification/host_strap_model.sv
// Purpose: host and strap model that drives the shared select pins
// Assumes: pins change right after a rising clock edge
// Notes:   a floating select pin shows the inverse of its last level
`timescale 1ns/1ns
module host_strap_model (
    input  wire logic clk_in,
    output logic      level_out,
    output logic      driven_out
);
    // idle: chip select high, pin driven
    initial begin
        level_out  = 1'b1;
        driven_out = 1'b1;
    end
    task automatic set_atten(input int code);
        @(posedge clk_in);
        driven_out <= (code != 2);
        level_out  <= (code == 2) ? ~level_out : code[0];
    endtask
    task automatic cs_open();
        @(posedge clk_in);
        level_out <= 1'b1;
        @(posedge clk_in);
        level_out <= 1'b0;
    endtask
    task automatic cs_close();
        @(posedge clk_in);
        level_out <= 1'b1;
    endtask
endmodule

// file: verification/tb_top.sv
// Purpose: self-checking bench for the pin decoder
// Assumes: AXI4-Lite master in this bench, pins driven at rising edges
// Notes:   a monitor compares bus answers against queued notes
`timescale 1ns/1ns
module tb_top;
    import line_cfg_pkg::*;
    logic        clk = 0;
    logic        rst = 1;
    logic        hw = 0, sty = 0, uni = 0, e1 = 0, oe = 1;
    logic        lvl, drv, acc, awr, wr, bv, arr, rv;
    line_cfg_t   cfg;
    logic [3:0]  tri_o;
    logic [7:0]  awa = 0, ara = 0;
    logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [31:0] wd = 0, rd;
    logic [3:0]  ws = 0;
    logic [1:0]  bresp, rresp;
    int          n_mismatch = 0, compares = 0, seed = 32'h566a8dc3;
    logic [1:0]  b_q[$];
    logic [33:0] r_q[$];

    always #10 clk = ~clk;

    host_strap_model u_host (.clk_in(clk), .level_out(lvl), .driven_out(drv));
    line_config_pin_decode u_dut (
        .REF_CLK_IN(clk), .RST_IN(rst), .HW_MODE_IN(hw), .CS_N_ATTEN_LEVEL_IN(lvl),
        .ATTEN_SEL_DRIVEN_IN(drv), .STYLE_CODE_SEL_IN(sty), .UNIPOLAR_IN(uni),
        .E1_MODE_IN(e1), .OUTPUT_ENABLE_IN(oe), .LINE_CFG_OUT(cfg),
        .HOST_ACCESS_OUT(acc), .TX_TRISTATE_OUT(tri_o), .S_AXI_AWADDR_IN(awa),
        .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
        .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr),
        .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
        .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
        .S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
        .S_AXI_RREADY_IN(rr));

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask

    task automatic finish_test();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // bus write: both channels offered, each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] r);
        bit aw_ok;
        bit w_ok;
        aw_ok = 0;
        w_ok = 0;
        b_q.push_back(r);
        @(posedge clk);
        awa <= a;
        awv <= 1'b1;
        wd <= d;
        ws <= s;
        wv <= 1'b1;
        br <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awv && awr) begin
                aw_ok = 1;
                awv <= 1'b0;
            end
            if (wv && wr) begin
                w_ok = 1;
                wv <= 1'b0;
            end
        end
        do @(posedge clk); while (!bv);
        br <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        r_q.push_back({r, d});
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        rr <= 1'b0;
    endtask

    task automatic pins(input logic h, s, u, e, o);
        @(posedge clk);
        hw <= h;
        sty <= s;
        uni <= u;
        e1 <= e;
        oe <= o;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    function automatic logic [31:0] stat(line_cfg_t c, logic h, logic o, logic a);
        return {21'h0, a, o, h, c.codec, 1'b0, c.bus_style, c.atten_pos};
    endfunction

    // monitor: oldest note against each answer
    always @(posedge clk) begin
        logic [33:0] n;
        if (bv && br) chk(32'(bresp), 32'(b_q.pop_front()), "write resp");
        if (rv && rr) begin
            n = r_q.pop_front();
            chk(rd, n[31:0], "read data");
            chk(32'(rresp), 32'(n[33:32]), "read resp");
        end
    end

    initial begin
        #200000;
        n_mismatch++;
        $display("mismatch %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        logic [31:0] v;
        logic [3:0]  q;
        line_cfg_t   e;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk(32'(cfg), 32'(CFG_RESET), "cfg reset");
        chk(tri_o, 4'h0, "tristate reset");
        axi_rd(TRISTATE_REG_OFFSET, 32'(TRISTATE_RESET), RESP_OKAY);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            v = (i < 4) ? (32'h1 << i) : $random(seed);
            q = v[3:0];
            axi_wr(TRISTATE_REG_OFFSET, v, 4'hf, RESP_OKAY);
            #1 chk(tri_o, q, "port tristate");
            axi_rd(TRISTATE_REG_OFFSET, {28'h0, q}, RESP_OKAY);
        end
        axi_wr(TRISTATE_REG_OFFSET, 32'ha, 4'hf, RESP_OKAY);
        axi_wr(TRISTATE_REG_OFFSET, 32'h0, 4'h0, RESP_OKAY);
        axi_wr(8'h08, v, 4'hf, RESP_SLVERR);
        axi_rd(8'h08, 32'h0, RESP_SLVERR);
        axi_wr(STATUS_REG_OFFSET, 32'hffffffff, 4'hf, RESP_OKAY);
        axi_rd(TRISTATE_REG_OFFSET, 32'ha, RESP_OKAY);
        $display("test software tristate done");
        for (int s = 0; s < 2; s++) begin
            pins(1'b0, s[0], 1'b1, s[0], 1'b1);
            settle();
            e = '{ATTEN_OFF, bus_style_t'(s[0]), CODE_NONE};
            chk(32'(cfg), 32'(e), "bus style");
            axi_rd(STATUS_REG_OFFSET, stat(e, 1'b0, 1'b1, 1'b0), RESP_OKAY);
        end
        pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        #1 chk(tri_o, 4'hf, "global disable");
        axi_wr(TRISTATE_REG_OFFSET, 32'h5, 4'hf, RESP_OKAY);
        settle();
        e = CFG_RESET;
        chk(32'(cfg), 32'(e), "decode while off");
        chk(tri_o, 4'hf, "still disabled");
        axi_rd(STATUS_REG_OFFSET, stat(e, 1'b0, 1'b0, 1'b0), RESP_OKAY);
        pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        #1 chk(tri_o, 4'h5, "enable restored");
        $display("test global enable done");
        for (int j = 0; j < 3; j++) begin
            u_host.set_atten(j);
            for (int k = 0; k < 8; k++) begin
                pins(1'b1, k[0], k[2], k[1], k[0]);
                settle();
                e.atten_pos = (j == 2) ? ATTEN_OFF : (j == 1) ? ATTEN_RX : ATTEN_TX;
                e.bus_style = BUS_STYLE_STROBE;
                e.codec = !k[2] ? CODE_NONE : k[0] ? CODE_AMI : k[1] ? CODE_HDB3 : CODE_B8ZS;
                chk(32'(cfg.atten_pos), 32'(e.atten_pos), "attenuator position");
                chk(32'(cfg), 32'(e), "line code");
                chk(tri_o, {4{~k[0]}}, "strap tristate");
            end
            axi_rd(STATUS_REG_OFFSET, stat(e, 1'b1, 1'b1, 1'b0), RESP_OKAY);
        end
        $display("test strap decode done");
        pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        u_host.set_atten(1);
        u_host.cs_open();
        @(posedge clk);
        #1 chk(acc, 1'b1, "access open with drivers off");
        chk(tri_o, 4'hf, "drivers off during access");
        axi_rd(STATUS_REG_OFFSET, stat(CFG_RESET, 1'b0, 1'b0, 1'b1), RESP_OKAY);
        u_host.cs_close();
        @(posedge clk);
        #1 chk(acc, 1'b0, "access closed");
        pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        u_host.cs_open();
        @(posedge clk);
        #1 chk(acc, 1'b0, "strap no access");
        $display("test chip select done");
        finish_test();
    end
endmodule
